// ===== hw/oc_defs.vh
/*
 * Constants of the three phase overcurrent stages: ranges, field codes,
 * reset values and timing counts. Assumes an including file that uses
 * these names only as values and the fixed 50 MHz mclk.
 */
// Function
// (RQ1) Compare largest fundamental phase magnitude only
// (RQ2) Assert start above the start threshold
// (RQ3) Trip after over-threshold outlasts operate delay
// (RQ4) Three stages, each with own settings
// (RQ5) First stage: fixed or inverse delay
// (RQ6) Second and third stages: fixed delay only
// (RQ7) Minimum fixed delay gives instantaneous trip
// (RQ8) Inverse delay shrinks as overcurrent grows
// (RQ9) Inverse curve families and types selectable
// (RQ10) Inverse multiplier 0.025 to 20.0
// (RQ11) Measured current saturates at fifty times nominal
// (RQ12) Harmonic option only on stages one, two
// (RQ13) Harmonic option compares true RMS value
// (RQ14) Harmonics add five milliseconds operate time
// (RQ15) Four setting groups, one active
// (RQ16) Stage one threshold 0.05-5.00, step 0.01
// (RQ17) Stage one delay 0.04-300.00 s
// (RQ18) Stage two threshold 0.10-20.00, step 0.01
// (RQ19) Stage two delay 0.04-1800.00 s
// (RQ20) Stage three threshold 0.10-40.00, step 0.01
// (RQ21) Stage three delay 0.03-300.00 s
// (RQ22) Zero delay only with zero acceptance
// (RQ23) Release below 0.97 times the threshold
// (RQ24) Trip drops together with start
`ifndef OC_DEFS_VH
`define OC_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define OC_MCLK_HZ 50000000
`define OC_HALF_TICK_MS 5
`define OC_HALF_TICK_CYC (`OC_MCLK_HZ / 1000 * `OC_HALF_TICK_MS)

// ****************************************
// Magnitudes, in 0.01 x nominal current
// ****************************************
`define OC_SAT_LIMIT 16'h1388
`define OC_REL_NUM 8'h61
`define OC_REL_DEN 8'h64

// ****************************************
// Setting ranges (threshold 0.01 x, delay 0.01 s, k 0.001)
// ****************************************
`define OC_THR1_MIN 12'h005
`define OC_THR1_MAX 12'h1f4
`define OC_THR2_MIN 12'h00a
`define OC_THR2_MAX 12'h7d0
`define OC_THR3_MIN 12'h00a
`define OC_THR3_MAX 12'hfa0
`define OC_DLY1_MIN 18'h00004
`define OC_DLY1_MAX 18'h07530
`define OC_DLY2_MIN 18'h00004
`define OC_DLY2_MAX 18'h2bf20
`define OC_DLY3_MIN 18'h00003
`define OC_DLY3_MAX 18'h07530
`define OC_K_MIN 15'h0019
`define OC_K_MAX 15'h4e20

// ****************************************
// Setting port fields and flag bits
// ****************************************
`define OC_FLD_THR 2'h0
`define OC_FLD_DLY 2'h1
`define OC_FLD_K 2'h2
`define OC_FLD_FLAGS 2'h3
`define OC_FLG_ZERO 0
`define OC_FLG_HARM 1
`define OC_FLG_INV 2
`define OC_FLG_FAM_LO 3
`define OC_FLG_TYP_LO 5

// ****************************************
// Curve families and types
// ****************************************
`define OC_FAM_DEF 2'h0
`define OC_FAM_IEC 2'h1
`define OC_FAM_IEEE 2'h2
`define OC_FAM_RI 2'h3
`define OC_TYP_EI 3'h0
`define OC_TYP_VI 3'h1
`define OC_TYP_NI 3'h2
`define OC_TYP_LTI 3'h3
`define OC_TYP_MI 3'h4
`define OC_UNIT_EI 8'h08
`define OC_UNIT_VI 8'h10
`define OC_UNIT_NI 8'h04
`define OC_UNIT_LTI 8'h78
`define OC_UNIT_MI 8'h02
`define OC_UNIT_RI 8'h06

// ****************************************
// Reset values
// ****************************************
`define OC_RST_THR 12'h064
`define OC_RST_DLY 18'h00064
`define OC_RST_K 15'h03e8
`define OC_RST_FLAGS 8'h00

`endif

// ===== hw/oc_stage.v
/*
 * One overcurrent stage: start with hysteresis, definite or inverse
 * operate timer, trip. Assumes saturated maximum magnitudes and
 * precomputed timer targets from the parent, all on mclk.
 */
`include "oc_defs.vh"

module oc_stage
(
    input wire mclk,
    input wire arst_n,
    input wire half_tick,
    input wire [15:0] imax_fund,
    input wire [15:0] imax_rms,
    input wire [11:0] thr,
    input wire harm_on,
    input wire inv_on,
    input wire [1:0] expo,
    input wire [31:0] target,
    output reg start,
    output reg trip
);

// ****************************************
// Measured quantity and comparisons
// ****************************************
wire [15:0] imax;
wire [15:0] thr_w;
wire above;
wire hold;
wire [23:0] lhs;
wire [23:0] rhs;
reg [2:0] level;
reg [3:0] shamt;
reg [31:0] weight;
reg [31:0] timer;
wire [31:0] next_timer;

assign imax = harm_on ? imax_rms : imax_fund; // [RQ13] [RQ1]
assign thr_w = {4'h0, thr};
assign above = imax > thr_w; // [RQ2]
assign lhs = imax * `OC_REL_DEN;
assign rhs = thr_w * `OC_REL_NUM;
// Ratio 0.97 keeps a marginal fault from chattering the start
assign hold = lhs >= rhs; // [RQ23]

// ****************************************
// Inverse weight: doubles of the threshold reached
// ****************************************
always @*
begin
    level = 3'h0;
    if (imax >= {thr_w[14:0], 1'b0})
        level = 3'h1;
    if (imax >= {thr_w[13:0], 2'b00})
        level = 3'h2;
    if (imax >= {thr_w[12:0], 3'b000})
        level = 3'h3;
    if (imax >= {thr_w[11:0], 4'h0})
        level = 3'h4;
    // Four bits hold the largest product, 4 x 3, without wrapping
    shamt = {1'b0, level} * {2'b00, expo};
    // Larger overcurrent, larger step, shorter delay
    weight = 32'h1 << shamt; // [RQ8]
end

assign next_timer = timer + (inv_on ? weight : 32'h1);

// ****************************************
// Start, timer and trip
// ****************************************
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        start <= 1'b0;
        trip <= 1'b0;
        timer <= 32'h0;
    end
    else if (!start)
    begin
        timer <= 32'h0;
        if (above)
        begin
            start <= 1'b1; // [RQ2]
            trip <= (target == 32'h0); // [RQ7]
        end
    end
    else if (!hold)
    begin
        start <= 1'b0; // [RQ23]
        trip <= 1'b0; // [RQ24]
        timer <= 32'h0;
    end
    else if (half_tick && !trip)
    begin
        timer <= next_timer;
        if (next_timer >= target)
            trip <= 1'b1; // [RQ3]
    end
end

endmodule // oc_stage

// ===== hw/phase_overcurrent_stages.v
/*
 * Three phase overcurrent stages with four setting groups each, a
 * setting write/read port, maximum phase selection and event pulses.
 * Assumes phase magnitudes from measurement logic on mclk, in units of
 * 0.01 x nominal, and a trip matrix that samples start and trip levels.
 */
`include "oc_defs.vh"

module phase_overcurrent_stages
#(
    parameter HALF_TICK_CYCLES = `OC_HALF_TICK_CYC
)
(
    input wire mclk,
    input wire arst_n,
    input wire [15:0] ia_fund,
    input wire [15:0] ib_fund,
    input wire [15:0] ic_fund,
    input wire [15:0] ia_rms,
    input wire [15:0] ib_rms,
    input wire [15:0] ic_rms,
    input wire [5:0] group_sel,
    input wire set_wr,
    input wire set_rd,
    input wire [1:0] set_stage,
    input wire [1:0] set_group,
    input wire [1:0] set_field,
    input wire [17:0] set_data,
    output reg [17:0] rd_data,
    output reg rd_valid,
    output reg set_reject,
    output reg [15:0] phase_max,
    output wire [2:0] start,
    output wire [2:0] trip,
    output reg [2:0] start_on,
    output reg [2:0] start_off,
    output reg [2:0] trip_on,
    output reg [2:0] trip_off
);

// ****************************************
// Half-tick timebase (5 ms)
// ****************************************
localparam integer TICK_LAST_I = HALF_TICK_CYCLES - 1;
localparam [17:0] TICK_LAST = TICK_LAST_I[17:0];
reg [17:0] tick_cnt;
reg half_tick;

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        tick_cnt <= 18'h0;
        half_tick <= 1'b0;
    end
    else
    begin
        half_tick <= (tick_cnt == TICK_LAST);
        if (tick_cnt == TICK_LAST)
            tick_cnt <= 18'h0;
        else
            tick_cnt <= tick_cnt + 18'h1;
    end
end

// ****************************************
// Saturation and largest phase
// ****************************************
wire [47:0] fund_all;
wire [47:0] rms_all;
wire [47:0] fund_sat;
wire [47:0] rms_sat;
reg [15:0] next_fmax;
reg [15:0] next_rmax;
reg [15:0] rms_max;

assign fund_all = {ic_fund, ib_fund, ia_fund};
assign rms_all = {ic_rms, ib_rms, ia_rms};

genvar p;
generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_sat
        // Measurement ceiling caps how far inverse curves can reach
        assign fund_sat[p*16 +: 16] =
            (fund_all[p*16 +: 16] > `OC_SAT_LIMIT) ?
            `OC_SAT_LIMIT : fund_all[p*16 +: 16]; // [RQ11]
        assign rms_sat[p*16 +: 16] =
            (rms_all[p*16 +: 16] > `OC_SAT_LIMIT) ?
            `OC_SAT_LIMIT : rms_all[p*16 +: 16]; // [RQ11]
    end
endgenerate

always @*
begin
    next_fmax = fund_sat[15:0];
    if (fund_sat[31:16] > next_fmax)
        next_fmax = fund_sat[31:16]; // [RQ1]
    if (fund_sat[47:32] > next_fmax)
        next_fmax = fund_sat[47:32]; // [RQ1]
    next_rmax = rms_sat[15:0];
    if (rms_sat[31:16] > next_rmax)
        next_rmax = rms_sat[31:16];
    if (rms_sat[47:32] > next_rmax)
        next_rmax = rms_sat[47:32];
end

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        phase_max <= 16'h0;
        rms_max <= 16'h0;
    end
    else
    begin
        phase_max <= next_fmax;
        rms_max <= next_rmax;
    end
end

// ****************************************
// Setting store: stage x group entries
// ****************************************
reg [11:0] thr_mem [0:11];
reg [17:0] dly_mem [0:11];
reg [14:0] k_mem [0:11];
reg [7:0] flg_mem [0:11];
wire [3:0] wr_idx;
reg [11:0] thr_min;
reg [11:0] thr_max;
reg [17:0] dly_min;
reg [17:0] dly_max;
reg [7:0] flg_mask;
reg [11:0] thr_clamp;
reg [17:0] dly_clamp;
reg [14:0] k_clamp;
integer i;

assign wr_idx = {set_stage, set_group};

// Per-stage limits; writes outside the range are pulled to the edge, except a zero delay
always @*
begin
    case (set_stage)
        2'h0:
        begin
            thr_min = `OC_THR1_MIN; // [RQ16]
            thr_max = `OC_THR1_MAX;
            dly_min = `OC_DLY1_MIN; // [RQ17]
            dly_max = `OC_DLY1_MAX;
            flg_mask = 8'hff; // [RQ5] [RQ12]
        end
        2'h1:
        begin
            thr_min = `OC_THR2_MIN; // [RQ18]
            thr_max = `OC_THR2_MAX;
            dly_min = `OC_DLY2_MIN; // [RQ19]
            dly_max = `OC_DLY2_MAX;
            flg_mask = 8'h03; // [RQ6]
        end
        default:
        begin
            thr_min = `OC_THR3_MIN; // [RQ20]
            thr_max = `OC_THR3_MAX;
            dly_min = `OC_DLY3_MIN; // [RQ21]
            dly_max = `OC_DLY3_MAX;
            flg_mask = 8'h01; // [RQ6] [RQ12]
        end
    endcase
    if (set_data > {6'h0, thr_max})
        thr_clamp = thr_max;
    else if (set_data < {6'h0, thr_min})
        thr_clamp = thr_min;
    else
        thr_clamp = set_data[11:0];
    // Zero is stored as zero; whether it is honoured is decided at use
    if (set_data == 18'h0)
        dly_clamp = 18'h0; // [RQ22]
    else if (set_data > dly_max)
        dly_clamp = dly_max;
    else if (set_data < dly_min)
        dly_clamp = dly_min;
    else
        dly_clamp = set_data;
    if (set_data > {3'h0, `OC_K_MAX})
        k_clamp = `OC_K_MAX; // [RQ10]
    else if (set_data < {3'h0, `OC_K_MIN})
        k_clamp = `OC_K_MIN; // [RQ10]
    else
        k_clamp = set_data[14:0];
end

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        for (i = 0; i < 12; i = i + 1)
        begin
            thr_mem[i] <= `OC_RST_THR;
            dly_mem[i] <= `OC_RST_DLY;
            k_mem[i] <= `OC_RST_K;
            flg_mem[i] <= `OC_RST_FLAGS;
        end
        rd_data <= 18'h0;
        rd_valid <= 1'b0;
        set_reject <= 1'b0;
    end
    else
    begin
        rd_valid <= set_rd && (set_stage != 2'h3);
        set_reject <= (set_wr || set_rd) && (set_stage == 2'h3);
        if (set_wr && set_stage != 2'h3)
        begin
            case (set_field) // [RQ15]
                `OC_FLD_THR: thr_mem[wr_idx] <= thr_clamp;
                `OC_FLD_DLY: dly_mem[wr_idx] <= dly_clamp;
                `OC_FLD_K: k_mem[wr_idx] <= k_clamp;
                default: flg_mem[wr_idx] <= set_data[7:0] & flg_mask;
            endcase
        end
        if (set_rd && set_stage != 2'h3)
        begin
            case (set_field)
                `OC_FLD_THR: rd_data <= {6'h0, thr_mem[wr_idx]};
                `OC_FLD_DLY: rd_data <= dly_mem[wr_idx];
                `OC_FLD_K: rd_data <= {3'h0, k_mem[wr_idx]};
                default: rd_data <= {10'h0, flg_mem[wr_idx]};
            endcase
        end
        else
            rd_data <= 18'h0;
    end
end

// ****************************************
// Active group decode and timer targets
// ****************************************
genvar s;
generate
    for (s = 0; s < 3; s = s + 1)
    begin : g_stage
        localparam integer SID_I = s;
        localparam [1:0] SID = SID_I[1:0];
        localparam [17:0] DMIN = (s == 2) ? `OC_DLY3_MIN : `OC_DLY1_MIN;
        wire [3:0] idx;
        wire [7:0] flg;
        wire [17:0] dly;
        wire [1:0] fam;
        wire [2:0] typ;
        wire harm;
        wire inv;
        reg [7:0] unit;
        reg [1:0] expo;
        reg [31:0] next_target;
        reg [31:0] target;
        reg [11:0] thr;
        reg harm_q;
        reg inv_q;
        reg [1:0] expo_q;
        reg start_q;
        reg trip_q;

        assign idx = {SID, group_sel[2*s +: 2]}; // [RQ15]
        assign flg = flg_mem[idx];
        assign dly = dly_mem[idx];
        assign fam = flg[`OC_FLG_FAM_LO +: 2];
        assign typ = flg[`OC_FLG_TYP_LO +: 3];
        assign harm = flg[`OC_FLG_HARM] && (s != 2); // [RQ12]
        // Definite family under inverse mode runs as a fixed delay
        assign inv = flg[`OC_FLG_INV] && (s == 0) &&
            (fam != `OC_FAM_DEF); // [RQ5] [RQ6] [RQ9]

        always @*
        begin
            case (typ) // [RQ9]
                `OC_TYP_EI: unit = `OC_UNIT_EI;
                `OC_TYP_VI: unit = `OC_UNIT_VI;
                `OC_TYP_NI: unit = `OC_UNIT_NI;
                `OC_TYP_LTI: unit = `OC_UNIT_LTI;
                default: unit = `OC_UNIT_MI;
            endcase
            case (typ)
                `OC_TYP_EI: expo = 2'h3;
                `OC_TYP_VI: expo = 2'h2;
                default: expo = 2'h1;
            endcase
            if (fam == `OC_FAM_RI)
            begin
                unit = `OC_UNIT_RI;
                expo = 2'h1;
            end
            if (inv)
                next_target = k_mem[idx] * unit; // [RQ10]
            // Zero honoured only when accepted; otherwise minimum
            else if ((dly == 18'h0 && flg[`OC_FLG_ZERO]) || dly <= DMIN)
                next_target = 32'h0; // [RQ7] [RQ22]
            else
                next_target = {13'h0, dly, 1'b0}; // [RQ3]
            if (harm)
                next_target = next_target + 32'h1; // [RQ14]
        end

        always @(posedge mclk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                target <= 32'h0;
                thr <= `OC_RST_THR;
                harm_q <= 1'b0;
                inv_q <= 1'b0;
                expo_q <= 2'h1;
                start_q <= 1'b0;
                trip_q <= 1'b0;
                start_on[s] <= 1'b0;
                start_off[s] <= 1'b0;
                trip_on[s] <= 1'b0;
                trip_off[s] <= 1'b0;
            end
            else
            begin
                target <= next_target;
                thr <= thr_mem[idx];
                harm_q <= harm;
                inv_q <= inv;
                expo_q <= expo;
                start_q <= start[s];
                trip_q <= trip[s];
                start_on[s] <= start[s] && !start_q;
                start_off[s] <= !start[s] && start_q;
                trip_on[s] <= trip[s] && !trip_q;
                trip_off[s] <= !trip[s] && trip_q;
            end
        end

        oc_stage u_stage // [RQ4]
        (
            .mclk(mclk),
            .arst_n(arst_n),
            .half_tick(half_tick),
            .imax_fund(phase_max),
            .imax_rms(rms_max),
            .thr(thr),
            .harm_on(harm_q),
            .inv_on(inv_q),
            .expo(expo_q),
            .target(target),
            .start(start[s]),
            .trip(trip[s])
        );
    end
endgenerate

endmodule // phase_overcurrent_stages

// ===== sim/meas_front.sv
/*
 * Phase current front end: the faulted phase carries the commanded
 * fundamental and RMS magnitudes, the others a light load.
 * Assumes the bench changes its commands at the falling edge.
 */
module meas_front
(
    input logic [15:0] f_lvl,
    input logic [15:0] r_lvl,
    input logic [1:0] f_ph,
    output logic [15:0] ia_fund,
    output logic [15:0] ib_fund,
    output logic [15:0] ic_fund,
    output logic [15:0] ia_rms,
    output logic [15:0] ib_rms,
    output logic [15:0] ic_rms
);
timeunit 1ns;
timeprecision 1ps;

// Light load stays under every threshold the bench sets in an active group
localparam logic [15:0] load_lvl = 16'h0032;

always_comb
begin
    ia_fund = (f_ph == 2'h0) ? f_lvl : load_lvl;
    ib_fund = (f_ph == 2'h1) ? f_lvl : load_lvl;
    ic_fund = (f_ph == 2'h2) ? f_lvl : load_lvl;
    ia_rms = (f_ph == 2'h0) ? r_lvl : load_lvl;
    ib_rms = (f_ph == 2'h1) ? r_lvl : load_lvl;
    ic_rms = (f_ph == 2'h2) ? r_lvl : load_lvl;
end

endmodule // meas_front

// ===== sim/oc_stages_properties.sv
/*
 * Concurrent checks on the overcurrent stages' ports.
 * Assumes one clock, mclk, and the asynchronous low reset arst_n.
 */
`include "oc_defs.vh"

module oc_stages_checker
#(
    parameter HALF_TICK_CYCLES = 250000
)
(
    input logic mclk,
    input logic arst_n,
    input logic [15:0] ia_fund,
    input logic [15:0] ib_fund,
    input logic [15:0] ic_fund,
    input logic set_wr,
    input logic set_rd,
    input logic [1:0] set_stage,
    input logic [17:0] rd_data,
    input logic rd_valid,
    input logic set_reject,
    input logic [15:0] phase_max,
    input logic [2:0] start,
    input logic [2:0] trip,
    input logic [2:0] start_on,
    input logic [2:0] start_off,
    input logic [2:0] trip_on,
    input logic [2:0] trip_off
);
timeunit 1ns;
timeprecision 1ps;

logic [15:0] m_ab;
logic [15:0] m_abc;
logic [15:0] m_sat;

assign m_ab = (ia_fund > ib_fund) ? ia_fund : ib_fund;
assign m_abc = (m_ab > ic_fund) ? m_ab : ic_fund;
assign m_sat = (m_abc > `OC_SAT_LIMIT) ? `OC_SAT_LIMIT : m_abc;

default clocking cb @(posedge mclk);
endclocking
default disable iff (!arst_n);

// ****************************************
// Properties
// ****************************************
chk_phase_max: assert property (
    $past(arst_n) |-> phase_max == $past(m_sat))
    else $error("phase maximum is not the saturated largest phase");
chk_trip_with_start: assert property (
    (trip & ~start) == 3'h0)
    else $error("trip without start");
chk_start_on_edge: assert property (
    start_on == ($past(start) & ~$past(start, 2)))
    else $error("start on pulse does not follow start rise");
chk_start_off_edge: assert property (
    start_off == (~$past(start) & $past(start, 2)))
    else $error("start off pulse does not follow start fall");
chk_trip_on_edge: assert property (
    $rose(trip[0]) |=> trip_on[0] ##1 !trip_on[0])
    else $error("trip on pulse missing or too long");
chk_off_together: assert property (
    trip_off != 3'h0 |-> (trip_off & ~start_off) == 3'h0)
    else $error("trip released apart from start");
chk_read_answer: assert property (
    set_rd && set_stage != 2'h3 |=> rd_valid)
    else $error("read not answered next cycle");
chk_read_cause: assert property (
    rd_valid |-> $past(set_rd) && $past(set_stage) != 2'h3)
    else $error("read data valid without a read");
chk_reject_pulse: assert property (
    (set_wr || set_rd) && set_stage == 2'h3 |=> set_reject && !rd_valid)
    else $error("access to missing stage not refused");
chk_read_idle: assert property (
    !rd_valid |-> rd_data == 18'h00000)
    else $error("read data not zero while idle");
chk_stage3_floor: assert property (
    $rose(start[2]) |-> $past(phase_max) > 16'h0009)
    else $error("stage three started under its lowest threshold");

endmodule // oc_stages_checker

bind phase_overcurrent_stages oc_stages_checker
    #(.HALF_TICK_CYCLES(HALF_TICK_CYCLES)) u_chk
(
    .mclk(mclk), .arst_n(arst_n), .ia_fund(ia_fund), .ib_fund(ib_fund),
    .ic_fund(ic_fund), .set_wr(set_wr), .set_rd(set_rd),
    .set_stage(set_stage), .rd_data(rd_data), .rd_valid(rd_valid),
    .set_reject(set_reject), .phase_max(phase_max), .start(start),
    .trip(trip), .start_on(start_on), .start_off(start_off),
    .trip_on(trip_on), .trip_off(trip_off)
);

// ===== sim/tb_top.sv
/*
 * Self-checking bench: settings port, start and trip timing,
 * hysteresis, groups, saturation and inverse curves.
 * Assumes oc_defs.vh on the include path and a shortened half tick.
 */
`include "oc_defs.vh"

module tb_top;
timeunit 1ns;
timeprecision 1ps;

localparam int half_tick_cyc = 10;
logic mclk = 1'b0;
logic arst_n = 1'b0;
logic [15:0] f_lvl = 16'h0000;
logic [15:0] r_lvl = 16'h0000;
logic [1:0] f_ph = 2'h0;
logic [5:0] group_sel = 6'h00;
logic set_wr = 1'b0;
logic set_rd = 1'b0;
logic [1:0] set_stage = 2'h0;
logic [1:0] set_group = 2'h0;
logic [1:0] set_field = 2'h0;
logic [17:0] set_data = 18'h00000;
logic [15:0] ia_fund, ib_fund, ic_fund, ia_rms, ib_rms, ic_rms;
logic [17:0] rd_data;
logic rd_valid, set_reject;
logic [15:0] phase_max;
logic [2:0] start, trip;
int checks = 0;
int n_mismatch = 0;

typedef struct {
    logic [1:0] st;
    logic [17:0] thr, dly, flg;
    logic [15:0] f, r;
    logic [1:0] ph;
    logic go;
    int t;
} row_t;

typedef struct {
    logic [1:0] st, fl;
    logic [17:0] d, e;
} reg_t;

row_t rows [8] = '{
    '{2'h0, 18'h64, 18'h5, 18'h0, 16'h96, 16'h0, 2'h0, 1'b1, 10},
    '{2'h1, 18'hc8, 18'h4, 18'h0, 16'hc9, 16'h0, 2'h1, 1'b1, 0},
    '{2'h2, 18'h12c, 18'h3, 18'h0, 16'h12c, 16'h0, 2'h2, 1'b0, 0},
    '{2'h2, 18'h12c, 18'h3, 18'h0, 16'h12d, 16'h0, 2'h2, 1'b1, 0},
    '{2'h1, 18'h64, 18'h0, 18'h0, 16'h96, 16'h0, 2'h0, 1'b1, 0},
    '{2'h0, 18'h64, 18'h5, 18'h2, 16'h32, 16'h96, 2'h1, 1'b1, 11},
    '{2'h2, 18'h64, 18'h5, 18'h2, 16'h32, 16'h96, 2'h2, 1'b0, 0},
    '{2'h1, 18'h64, 18'h6, 18'h2, 16'h32, 16'h96, 2'h0, 1'b1, 13}};

reg_t regs [15] = '{
    '{2'h0, 2'h0, 18'h1, 18'h5}, '{2'h0, 2'h0, 18'h1388, 18'h1f4},
    '{2'h1, 2'h0, 18'h1388, 18'h7d0}, '{2'h2, 2'h0, 18'h1388, 18'hfa0},
    '{2'h2, 2'h0, 18'h1, 18'ha}, '{2'h0, 2'h1, 18'h3ffff, 18'h7530},
    '{2'h1, 2'h1, 18'h3ffff, 18'h2bf20}, '{2'h1, 2'h1, 18'h1, 18'h4},
    '{2'h2, 2'h1, 18'h1, 18'h3}, '{2'h2, 2'h1, 18'h0, 18'h0},
    '{2'h0, 2'h2, 18'h1, 18'h19}, '{2'h0, 2'h2, 18'h3ffff, 18'h4e20},
    '{2'h0, 2'h3, 18'hff, 18'hff}, '{2'h1, 2'h3, 18'hff, 18'h3},
    '{2'h2, 2'h3, 18'hff, 18'h1}};

logic [17:0] rst_exp [4] = '{18'h64, 18'h64, 18'h3e8, 18'h0};

always #10 mclk = ~mclk;

meas_front u_front
(
    .f_lvl(f_lvl), .r_lvl(r_lvl), .f_ph(f_ph), .ia_fund(ia_fund),
    .ib_fund(ib_fund), .ic_fund(ic_fund), .ia_rms(ia_rms),
    .ib_rms(ib_rms), .ic_rms(ic_rms)
);

phase_overcurrent_stages #(.HALF_TICK_CYCLES(half_tick_cyc)) u_dut
(
    .mclk(mclk), .arst_n(arst_n), .ia_fund(ia_fund), .ib_fund(ib_fund),
    .ic_fund(ic_fund), .ia_rms(ia_rms), .ib_rms(ib_rms), .ic_rms(ic_rms),
    .group_sel(group_sel), .set_wr(set_wr), .set_rd(set_rd),
    .set_stage(set_stage), .set_group(set_group), .set_field(set_field),
    .set_data(set_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .set_reject(set_reject), .phase_max(phase_max), .start(start),
    .trip(trip), .start_on(), .start_off(), .trip_on(), .trip_off()
);

// ****************************************
// Tasks
// ****************************************
task automatic cmp(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp)
    begin
        n_mismatch++;
        $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
endtask

task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask

// Ends one falling edge after the taking edge, answer visible
task automatic access(input logic wr, input logic [1:0] st,
    input logic [1:0] gr, input logic [1:0] fl, input logic [17:0] d);
    @(negedge mclk);
    set_wr = wr;
    set_rd = ~wr;
    set_stage = st;
    set_group = gr;
    set_field = fl;
    set_data = d;
    @(negedge mclk);
    set_wr = 1'b0;
    set_rd = 1'b0;
endtask

task automatic setup(input logic [1:0] st, input logic [17:0] thr,
    input logic [17:0] dly, input logic [17:0] flg);
    access(1'b1, st, 2'h0, `OC_FLD_THR, thr);
    access(1'b1, st, 2'h0, `OC_FLD_DLY, dly);
    access(1'b1, st, 2'h0, `OC_FLD_FLAGS, flg);
endtask

task automatic fault(input logic [15:0] f, input logic [15:0] r,
    input logic [1:0] p);
    @(negedge mclk);
    f_lvl = f;
    r_lvl = r;
    f_ph = p;
endtask

// Falling edges from fault onset to trip; 3000 means none
task automatic trip_time(input int st, input logic [15:0] f,
    input logic [15:0] r, input logic [1:0] p, output int n);
    fault(16'h0000, 16'h0000, 2'h0);
    repeat (4) @(negedge mclk);
    fault(f, r, p);
    n = 0;
    while (trip[st] !== 1'b1 && n < 3000)
    begin
        @(negedge mclk);
        n++;
    end
endtask

// ****************************************
// Main sequence
// ****************************************
initial
begin
    int n, t, lo, hi;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
        access(1'b0, 2'h1, 2'h2, i[1:0], 18'h0);
        cmp(rd_data, rst_exp[i]);
    end
    foreach (regs[i])
    begin
        access(1'b1, regs[i].st, 2'h3, regs[i].fl, regs[i].d);
        access(1'b0, regs[i].st, 2'h3, regs[i].fl, 18'h0);
        cmp(rd_data, regs[i].e);
    end
    access(1'b1, 2'h3, 2'h0, 2'h0, 18'h1);
    cmp(set_reject, 1'b1);
    access(1'b0, 2'h3, 2'h0, 2'h0, 18'h0);
    cmp({set_reject, rd_valid}, 2'b10);
    foreach (rows[i])
    begin
        setup(rows[i].st, rows[i].thr, rows[i].dly, rows[i].flg);
        trip_time(rows[i].st, rows[i].f, rows[i].r, rows[i].ph, n);
        cmp(start[rows[i].st], rows[i].go);
        t = rows[i].t;
        lo = t ? 2 + (t - 1) * half_tick_cyc : 2;
        hi = t ? 4 + t * half_tick_cyc : 2;
        cmp(rows[i].go ? (n >= lo && n <= hi) : n == 3000, 1'b1);
    end
    // Instant stage: start and trip must hold in the band, drop below
    setup(2'h1, 18'h64, 18'h4, 18'h0);
    trip_time(1, 16'h0096, 16'h0, 2'h0, n);
    fault(16'h0062, 16'h0, 2'h0);
    repeat (4) @(negedge mclk);
    cmp({start[1], trip[1]}, 2'b11);
    fault(16'h0060, 16'h0, 2'h0);
    repeat (3) @(negedge mclk);
    cmp({start[1], trip[1]}, 2'b00);
    setup(2'h0, 18'h64, 18'h7530, 18'h0);
    access(1'b1, 2'h0, 2'h1, `OC_FLD_THR, 18'h12c);
    fault(16'h00c8, 16'h0, 2'h1);
    repeat (3) @(negedge mclk);
    cmp(start[0], 1'b1);
    group_sel = 6'h01;
    repeat (4) @(negedge mclk);
    cmp(start[0], 1'b0);
    group_sel = 6'h00;
    fault(16'hffff, 16'h0, 2'h2);
    repeat (2) @(negedge mclk);
    cmp(phase_max, 16'h1388);
    fault(16'h0457, 16'hffff, 2'h1);
    repeat (2) @(negedge mclk);
    cmp(phase_max, 16'h0457);
    setup(2'h0, 18'h64, 18'h64, 18'h0);
    access(1'b1, 2'h0, 2'h0, `OC_FLD_K, 18'h19);
    for (int fm = 0; fm < 4; fm++)
        for (int ty = 0; ty < 5; ty++)
        begin
            access(1'b1, 2'h0, 2'h0, `OC_FLD_FLAGS, 18'(4 + fm * 8 + ty * 32));
            trip_time(0, 16'h06a4, 16'h0, 2'h0, n);
            cmp(n < 3000, 1'b1);
        end
    access(1'b1, 2'h0, 2'h0, `OC_FLD_FLAGS, 18'h4c);
    trip_time(0, 16'h0096, 16'h0, 2'h0, n);
    trip_time(0, 16'h01c2, 16'h0, 2'h0, t);
    cmp(t < n, 1'b1);
    access(1'b1, 2'h0, 2'h0, `OC_FLD_FLAGS, 18'h0c);
    trip_time(0, 16'h0190, 16'h0, 2'h0, n);
    trip_time(0, 16'h0320, 16'h0, 2'h0, t);
    cmp(t < n, 1'b1);
    end_of_test();
end

// Whole run needs about 23k cycles
initial
begin
    #2000000;
    n_mismatch++;
    end_of_test();
end

endmodule // tb_top
